/* File: hw/mcu_clock_generation.sv */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module mcu_clock_generation #(
   parameter int unsigned SLOW_STAB_COUNT = clk_gen_pkg::SLOW_STAB_PULSES,
   parameter int unsigned FAST_RESET_COUNT = clk_gen_pkg::FAST_RESET_PULSES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [17:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Power mode controls, same clock domain
   input wire logic stop_enter,
   input wire logic ext_wake,
   // Oscillator pins and analog sources
   input wire logic crystal_in_pin,
   output logic crystal_out_pin_o,
   output logic crystal_out_pin_oe,
   output logic slow_osc_power,
   input wire logic rc_osc_in,
   output logic rc_osc_run,
   input wire logic ext_fast_clock_pin,
   // Generated clocks and CPU stall
   output logic slow_clock,
   output logic doubled_slow_clock,
   output logic raw_fast_osc_clock,
   output logic divided_fast_clock,
   output logic port_output_clock,
   output logic cpu_clk_out,
   output logic cpu_stall
);

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   clk_gen_pkg::fast_cfg_t fast_cfg_r;
   clk_gen_pkg::en_sel_t en_sel_r;
   clk_gen_pkg::mux_state_t mux_r;
   logic stop_mode_r;
   logic fast_after_reset_r;
   logic rc_s1_r, rc_s2_r, rc_d_r;
   logic xt_s1_r, xt_s2_r, xt_d_r;
   logic ext_s1_r, ext_s2_r, ext_d_r;
   logic fast_level, fast_rise, fast_run;
   logic slow_rise, slow_edge, slow_run;
   logic slow_ready, fast_ready;
   logic sys_div_clk, out_div_clk;
   logic [13:0] fast_target;
   logic [8:0] half_cnt_r;
   logic [8:0] half_len_r;
   logic bus_hit_r;
   logic wr_fire, rd_now;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Oscillator levels are asynchronous to sys_clk; two stages each
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         xt_s1_r <= 1'b0;
         xt_s2_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         rc_s1_r <= rc_osc_in;
         rc_s2_r <= rc_s1_r;
         xt_s1_r <= crystal_in_pin;
         xt_s2_r <= xt_s1_r;
         ext_s1_r <= ext_fast_clock_pin;
         ext_s2_r <= ext_s1_r;
      end
   end

   // Delayed copies for edge detection, fed from the second stage only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rc_d_r <= 1'b0;
         xt_d_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         rc_d_r <= rc_s2_r;
         xt_d_r <= xt_s2_r;
         ext_d_r <= ext_s2_r;
      end
   end

   // Source selection by mode bit
   always_comb begin
      fast_level = fast_cfg_r.src_mode ? ext_s2_r : rc_s2_r; // RULE2
      fast_rise = fast_cfg_r.src_mode ? (ext_s2_r & ~ext_d_r)
                                      : (rc_s2_r & ~rc_d_r);
      fast_run = en_sel_r.osc_en & ~stop_mode_r; // RULE8
      slow_run = ~stop_mode_r;
      slow_rise = xt_s2_r & ~xt_d_r;
      slow_edge = xt_s2_r ^ xt_d_r;
   end

   // ---------------------------------------------------------------
   // STOP mode
   // ---------------------------------------------------------------
   // Wake wins over a simultaneous entry so a wake is never lost
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stop_mode_r <= 1'b0;
      end else if (ext_wake) begin
         stop_mode_r <= 1'b0; // RULE13
      end else if (stop_enter) begin
         stop_mode_r <= 1'b1; // RULE12
      end
   end

   // Oscillator power and crystal pin drive
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         slow_osc_power <= 1'b1; // RULE11
         crystal_out_pin_o <= 1'b0;
         crystal_out_pin_oe <= 1'b1;
         rc_osc_run <= 1'b1;
      end else begin
         slow_osc_power <= slow_run; // RULE12
         crystal_out_pin_o <= ~xt_s2_r;
         crystal_out_pin_oe <= slow_run; // RULE12
         rc_osc_run <= fast_run & ~fast_cfg_r.src_mode;
      end
   end

   // ---------------------------------------------------------------
   // Stabilisation
   // ---------------------------------------------------------------
   // The long count applies only to the first start after reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fast_after_reset_r <= 1'b1;
      end else if (fast_ready) begin
         fast_after_reset_r <= 1'b0;
      end
   end

   always_comb begin
      fast_target = fast_after_reset_r ? 14'(FAST_RESET_COUNT) // RULE17
                    : 14'(clk_gen_pkg::FAST_STAB_PULSES); // RULE16
   end

   osc_stab_counter #(.W(14)) slow_stab (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(slow_run), // RULE20
      .pulse(slow_rise),
      .start_cycles(12'(clk_gen_pkg::SLOW_START_CYC)),
      .target(14'(SLOW_STAB_COUNT)), // RULE11
      .ready(slow_ready)
   );

   osc_stab_counter #(.W(14)) fast_stab (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(fast_run), // RULE20
      .pulse(fast_rise),
      .start_cycles(12'(clk_gen_pkg::FAST_START_CYC)),
      .target(fast_target),
      .ready(fast_ready)
   );

   // ---------------------------------------------------------------
   // Dividers
   // ---------------------------------------------------------------
   clk_div_sel sys_div (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(fast_run),
      .src_level(fast_level),
      .src_rise(fast_rise),
      .sel(fast_cfg_r.fast_div), // RULE1
      .div_clk(sys_div_clk)
   );

   clk_div_sel out_div (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(fast_run),
      .src_level(fast_level),
      .src_rise(fast_rise),
      .sel(fast_cfg_r.out_div), // RULE4
      .div_clk(out_div_clk)
   );

   // Clocks reach their users only once the source is stable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         slow_clock <= 1'b0;
         raw_fast_osc_clock <= 1'b0;
         divided_fast_clock <= 1'b0;
         port_output_clock <= 1'b0;
      end else begin
         slow_clock <= slow_ready & xt_s2_r; // RULE11 RULE13
         raw_fast_osc_clock <= fast_ready & fast_level; // RULE16
         divided_fast_clock <= fast_ready & sys_div_clk; // RULE1
         port_output_clock <= fast_ready & out_div_clk; // RULE4
      end
   end

   // ---------------------------------------------------------------
   // Doubled slow clock
   // ---------------------------------------------------------------
   // Measures the slow half period, then toggles at its midpoint too;
   // the first half period after enable may be uneven
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         half_cnt_r <= 9'h000;
         half_len_r <= 9'h000;
      end else if (slow_edge) begin
         half_len_r <= half_cnt_r;
         half_cnt_r <= 9'h000;
      end else if (half_cnt_r != 9'h1ff) begin
         half_cnt_r <= half_cnt_r + 9'h001;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         doubled_slow_clock <= 1'b0;
      end else if (!(en_sel_r.dbl_en && slow_ready)) begin
         doubled_slow_clock <= 1'b0; // RULE9
      end else if (slow_edge) begin
         doubled_slow_clock <= 1'b1; // RULE9
      end else if (half_cnt_r == {1'b0, half_len_r[8:1]}) begin
         doubled_slow_clock <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // CPU clock mux
   // ---------------------------------------------------------------
   // Leave the old source and join the new one only while each is low so no pulse is cut
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mux_r <= clk_gen_pkg::MUX_TO_FAST; // RULE10
      end else begin
         unique case (mux_r)
            clk_gen_pkg::MUX_SLOW: begin
               if (en_sel_r.cpu_sel && !slow_clock) begin
                  mux_r <= clk_gen_pkg::MUX_TO_FAST; // RULE19
               end
            end
            clk_gen_pkg::MUX_TO_FAST: begin
               if (!en_sel_r.cpu_sel) begin
                  mux_r <= clk_gen_pkg::MUX_TO_SLOW;
               end else if (fast_ready && !divided_fast_clock) begin
                  mux_r <= clk_gen_pkg::MUX_FAST; // RULE18 RULE19
               end
            end
            clk_gen_pkg::MUX_FAST: begin
               if (!en_sel_r.cpu_sel && !divided_fast_clock) begin
                  mux_r <= clk_gen_pkg::MUX_TO_SLOW; // RULE19
               end
            end
            clk_gen_pkg::MUX_TO_SLOW: begin
               if (en_sel_r.cpu_sel) begin
                  mux_r <= clk_gen_pkg::MUX_TO_FAST;
               end else if (slow_ready && !slow_clock) begin
                  mux_r <= clk_gen_pkg::MUX_SLOW; // RULE14 RULE19
               end
            end
         endcase
      end
   end

   // Output held low and CPU stalled while a source is awaited
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_clk_out <= 1'b0;
         cpu_stall <= 1'b1;
      end else begin
         unique case (mux_r)
            clk_gen_pkg::MUX_SLOW: cpu_clk_out <= slow_clock; // RULE6
            clk_gen_pkg::MUX_FAST: cpu_clk_out <= divided_fast_clock;
            default: cpu_clk_out <= 1'b0;
         endcase
         cpu_stall <= (mux_r == clk_gen_pkg::MUX_TO_FAST) // RULE18
                      || (mux_r == clk_gen_pkg::MUX_TO_SLOW); // RULE14
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------
   // Every access waits exactly one cycle; wait drops for one cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
         avs_waitrequest <= 1'b0;
      end
   end

   always_comb begin
      wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
      rd_now = avs_read & avs_waitrequest;
      unique case (avs_address)
         clk_gen_pkg::FAST_CFG_ADDR: rd_mux = {24'h00_0000, fast_cfg_r};
         clk_gen_pkg::EN_SEL_ADDR: rd_mux = {24'h00_0000, en_sel_r};
         clk_gen_pkg::STATUS_ADDR:
            rd_mux = {24'h00_0000, 1'b0, mux_r, stop_mode_r, cpu_stall,
                      fast_after_reset_r, fast_ready, slow_ready};
         default: rd_mux = 32'h0000_0000; // Unmapped reads as zero
      endcase
   end

   // Read data is captured as wait drops and held until the next read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h0000_0000;
         bus_hit_r <= 1'b0;
      end else if (rd_now) begin
         avs_readdata <= rd_mux;
         bus_hit_r <= 1'b1;
      end else begin
         bus_hit_r <= 1'b0;
      end
   end

   // Fast clock configuration register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fast_cfg_r <= clk_gen_pkg::FAST_CFG_RESET; // RULE1 RULE2 RULE4
      end else if (wr_fire && avs_address == clk_gen_pkg::FAST_CFG_ADDR) begin
         fast_cfg_r.fast_div <= avs_writedata[1:0]; // RULE1
         fast_cfg_r.out_div <= avs_writedata[5:4]; // RULE4
         if (!en_sel_r.osc_en) begin
            fast_cfg_r.src_mode <=
               avs_writedata[clk_gen_pkg::SRC_MODE_BIT]; // RULE3
         end
      end
   end

   // Enable and select register; select cannot stand without enable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         en_sel_r <= clk_gen_pkg::EN_SEL_RESET; // RULE6 RULE8 RULE9
      end else if (wr_fire && avs_address == clk_gen_pkg::EN_SEL_ADDR) begin
         en_sel_r.osc_en <= avs_writedata[clk_gen_pkg::OSC_EN_BIT]; // RULE8
         en_sel_r.dbl_en <= avs_writedata[clk_gen_pkg::DBL_EN_BIT]; // RULE9
         en_sel_r.cpu_sel <= avs_writedata[clk_gen_pkg::SEL_BIT]
                             & avs_writedata[clk_gen_pkg::OSC_EN_BIT]; // RULE7
      end
   end

endmodule

/* File: hw/clk_gen_pkg.sv */
//
// Behaviour
// RULE1: Fast clock is oscillator clock divided by 1/2/4/8; 8 after reset.
// RULE2: Mode bit 2 picks RC (0) or external clock (1); RC after reset.
// RULE3: Mode writes take effect only while fast oscillation is off.
// RULE4: Output divider bits 5:4 divide by 1/2/4/8; 8 after reset.
// RULE5: Software stops fast oscillator, selects slow, then changes mode.
// RULE6: Select bit 0 routes slow (0) or fast (1) clock; fast after reset.
// RULE7: With fast oscillator disabled, select bit reads 0 and CPU runs slow.
// RULE8: Enable bit 1 starts or stops fast oscillator; enabled after reset.
// RULE9: Doubler bit 2 of second register makes 64 kHz; off after reset.
// RULE10: After reset the CPU runs from RC oscillator divided by 8.
// RULE11: Slow clock delivered after start time plus 8192 slow cycles.
// RULE12: STOP halts and unpowers slow oscillator, floats crystal pins.
// RULE13: STOP release restarts slow; delivery waits start and stabilisation.
// RULE14: Switching to slow before it runs stalls CPU until delivery starts.
// RULE15: Software should see the 128 Hz tick flag set before selecting slow.
// RULE16: In RC mode the fast clock is supplied after 128 RC pulses.
// RULE17: After system reset the fast clock is withheld for 8192 RC pulses.
// RULE18: Switching to fast before it runs stalls CPU until delivery starts.
// RULE19: CPU mux hands over without cut pulses, once new source is valid.
// RULE20: Stability counts clear on stop and restart as oscillation resumes.
package clk_gen_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SLOW_START_NS = 100000;
   localparam int unsigned FAST_START_NS = 10000;
   localparam int unsigned SLOW_START_CYC =
      (SLOW_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FAST_START_CYC =
      (FAST_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SLOW_STAB_PULSES = 8192;
   localparam int unsigned FAST_RESET_PULSES = 8192;
   localparam int unsigned FAST_STAB_PULSES = 128;

   // ---------------------------------------------------------------
   // Register map (index, byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] FAST_CFG_IDX = 16'hf002;
   localparam logic [15:0] EN_SEL_IDX = 16'hf003;
   localparam logic [15:0] STATUS_IDX = 16'hf004;
   localparam logic [17:0] FAST_CFG_ADDR = {FAST_CFG_IDX, 2'b00};
   localparam logic [17:0] EN_SEL_ADDR = {EN_SEL_IDX, 2'b00};
   localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
   localparam logic [7:0] FAST_CFG_RESET = 8'h33;
   localparam logic [7:0] EN_SEL_RESET = 8'h03;

   // Field positions
   localparam int unsigned SEL_BIT = 0;
   localparam int unsigned OSC_EN_BIT = 1;
   localparam int unsigned SRC_MODE_BIT = 2;
   localparam int unsigned DBL_EN_BIT = 2;

   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic [1:0] out_div;
      logic rsvd3;
      logic src_mode;
      logic [1:0] fast_div;
   } fast_cfg_t;

   typedef struct packed {
      logic [4:0] rsvd;
      logic dbl_en;
      logic osc_en;
      logic cpu_sel;
   } en_sel_t;

   // CPU clock mux states, Gray ring
   typedef enum logic [1:0] {
      MUX_SLOW = 2'b00,
      MUX_TO_FAST = 2'b01,
      MUX_FAST = 2'b11,
      MUX_TO_SLOW = 2'b10
   } mux_state_t;

endpackage

/* File: hw/osc_stab_counter.sv */
`timescale 1ns/1ps
module osc_stab_counter #(
   parameter int unsigned W = 14
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic pulse,
   input wire logic [11:0] start_cycles,
   input wire logic [W-1:0] target,
   output logic ready
);

   logic [11:0] start_cnt_r;
   logic [W-1:0] pulse_cnt_r;
   logic started_r;

   // Start period timed on the system clock, then oscillator pulses
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         start_cnt_r <= 12'h000;
         started_r <= 1'b0;
      end else if (!run) begin
         start_cnt_r <= 12'h000; // RULE20
         started_r <= 1'b0;
      end else if (!started_r) begin
         if (start_cnt_r >= start_cycles) begin
            started_r <= 1'b1;
         end else begin
            start_cnt_r <= start_cnt_r + 12'h001;
         end
      end
   end

   // Pulse count; ready holds until the oscillator stops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pulse_cnt_r <= '0;
         ready <= 1'b0;
      end else if (!run) begin
         pulse_cnt_r <= '0; // RULE20
         ready <= 1'b0;
      end else if (started_r && !ready && pulse) begin
         pulse_cnt_r <= pulse_cnt_r + 1'b1;
         if (pulse_cnt_r + 1'b1 == target) begin
            ready <= 1'b1;
         end
      end
   end

endmodule

/* File: hw/clk_div_sel.sv */
`timescale 1ns/1ps
module clk_div_sel (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic src_level,
   input wire logic src_rise,
   input wire logic [1:0] sel,
   output logic div_clk
);

   logic [2:0] cnt_r;

   // Rising edges of the source advance a ripple-free count
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 3'h0;
      end else if (!run) begin
         cnt_r <= 3'h0;
      end else if (src_rise) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // Code 0 passes the source, codes 1..3 take count bits 0..2
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         div_clk <= 1'b0;
      end else if (!run) begin
         div_clk <= 1'b0;
      end else begin
         unique case (sel)
            2'b00: div_clk <= src_level;
            2'b01: div_clk <= cnt_r[0];
            2'b10: div_clk <= cnt_r[1];
            2'b11: div_clk <= cnt_r[2];
         endcase
      end
   end

endmodule

/* File: sim/mcu_clock_generation_assertions.sv */
`timescale 1ns/1ps
module mcu_clock_generation_assertions (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic stop_enter,
   input wire logic ext_wake,
   input wire logic slow_osc_power,
   input wire logic crystal_out_pin_oe,
   input wire logic slow_clock,
   input wire logic doubled_slow_clock,
   input wire logic divided_fast_clock,
   input wire logic cpu_clk_out,
   input wire logic cpu_stall
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Start times in cycles, no clock may show before these run out
   localparam int START_SLOW = 1001;
   localparam int START_FAST = 101;
   logic [11:0] rst_cyc_r;
   logic [11:0] wake_cyc_r;
   logic in_stop_r;
   logic woke_r;

   // ------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------
   // Cycles since reset release, saturating so it never wraps
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) rst_cyc_r <= 12'h000;
      else if (rst_cyc_r != 12'hfff) rst_cyc_r <= rst_cyc_r + 12'h001;
   end
   // Mirror of STOP, and cycles since a wake that left STOP
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         in_stop_r <= 1'b0;
         woke_r <= 1'b0;
         wake_cyc_r <= 12'h000;
      end else begin
         in_stop_r <= (in_stop_r || stop_enter) && !ext_wake;
         if (ext_wake && in_stop_r) begin
            woke_r <= 1'b1;
            wake_cyc_r <= 12'h000;
         end else if (wake_cyc_r != 12'hfff) begin
            wake_cyc_r <= wake_cyc_r + 12'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   bus_answer_a:
      assert property ((avs_read || avs_write) && avs_waitrequest
         |=> !avs_waitrequest) else $error("bus request not answered");
   bus_once_a:
      assert property (!avs_waitrequest |=> avs_waitrequest)
         else $error("waitrequest low too long");
   bus_idle_a:
      assert property (!(avs_read || avs_write) |=> avs_waitrequest)
         else $error("answer without request");
   stop_pins_a:
      assert property (stop_enter && !ext_wake |-> ##[1:2]
         (!slow_osc_power && !crystal_out_pin_oe))
         else $error("crystal still powered in stop");
   stop_silence_a:
      assert property (!slow_osc_power [*3] |-> !slow_clock)
         else $error("slow clock runs while unpowered");
   wake_slow_wait_a:
      assert property (woke_r && wake_cyc_r < START_SLOW |-> !slow_clock)
         else $error("slow clock too early after wake");
   reset_fast_hold_a:
      assert property (rst_cyc_r < START_FAST
         |-> cpu_stall && !divided_fast_clock)
         else $error("fast clock too early after reset");
   reset_slow_hold_a:
      assert property (rst_cyc_r < START_SLOW
         |-> !slow_clock && !doubled_slow_clock)
         else $error("slow clock too early after reset");
   handover_low_a:
      assert property (cpu_stall [*2] |-> !cpu_clk_out)
         else $error("cpu clock pulses during handover");
endmodule

/* File: sim/mcu_clock_generation_tb_top.sv */
`timescale 1ns/1ps
module mcu_clock_generation_tb_top;
   localparam logic [17:0] FA = clk_gen_pkg::FAST_CFG_ADDR;
   localparam logic [17:0] EA = clk_gen_pkg::EN_SEL_ADDR;
   localparam logic [17:0] NA = 18'h3_c014;
   typedef struct {
      logic [17:0] addr; logic [7:0] wd; logic [7:0] ex;
      int n_div; int n_out; int n_dbl;
   } row_t;
   // Rise counts per 128 cycles; a negative count is not compared
   row_t rows [8] = '{
      '{FA, 8'h00, 8'h00, 32, 32, 0},
      '{FA, 8'h15, 8'h11, 16, 16, 0},
      '{FA, 8'h22, 8'h22, 8, 8, 0},
      '{EA, 8'h06, 8'h06, 8, 8, 8},
      '{EA, 8'h05, 8'h04, 0, -1, 8},
      '{FA, 8'h37, 8'h37, 0, -1, 8},
      '{FA, 8'h33, 8'h33, 0, -1, 8},
      '{NA, 8'hff, 8'h00, 0, -1, 8}};
   logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [17:0] avs_address;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_writedata, avs_readdata;
   logic stop_enter, ext_wake, crystal_in_pin, rc_osc_in;
   logic ext_fast_clock_pin, crystal_out_pin_o, crystal_out_pin_oe;
   logic slow_osc_power, rc_osc_run, slow_clock, doubled_slow_clock;
   logic raw_fast_osc_clock, divided_fast_clock, port_output_clock;
   logic cpu_clk_out, cpu_stall;
   logic [15:0] cyc = 16'h0000, t0;
   logic [7:0] d;
   int error_cnt = 0;
   int checked = 0;
   int nd, no, nb, ns;

   mcu_clock_generation #(.SLOW_STAB_COUNT(16), .FAST_RESET_COUNT(16))
   mcu_clock_generation_inst (.*);

   // ------------------------------------------------------------
   // Clock, oscillators and watchdog
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Oscillators stop when unpowered, so gating bugs cannot hide
   always @(posedge sys_clk) begin
      cyc <= cyc + 16'h0001;
      rc_osc_in <= rc_osc_run & cyc[1];
      crystal_in_pin <= slow_osc_power & cyc[4];
      ext_fast_clock_pin <= cyc[2];
      if (cyc == 16'h2ee0) begin
         error_cnt++;
         $display("CHECK FAILED watchdog expected finish seen hang");
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(string what, logic [31:0] ex, logic [31:0] got);
      checked++;
      if (got !== ex) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, ex, got);
      end
   endtask
   // Request held until waitrequest is sampled low, then released
   task automatic bus(logic wr, logic [17:0] a, logic [7:0] wd);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      d = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic count_rises();
      logic pd, po, pb, ps;
      nd = 0; no = 0; nb = 0; ns = 0;
      pd = divided_fast_clock; po = port_output_clock;
      pb = doubled_slow_clock; ps = slow_clock;
      repeat (128) begin
         @(posedge sys_clk);
         if (divided_fast_clock === 1'b1 && pd === 1'b0) nd++;
         if (port_output_clock === 1'b1 && po === 1'b0) no++;
         if (doubled_slow_clock === 1'b1 && pb === 1'b0) nb++;
         if (slow_clock === 1'b1 && ps === 1'b0) ns++;
         pd = divided_fast_clock; po = port_output_clock;
         pb = doubled_slow_clock; ps = slow_clock;
      end
   endtask
   task automatic wait_stall_low();
      while (cpu_stall !== 1'b0) @(posedge sys_clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
      avs_address = 18'h0_0000; avs_writedata = 32'h0000_0000;
      stop_enter = 1'b0; ext_wake = 1'b0;
      repeat (4) @(posedge sys_clk);
      check("stall in reset", 1, cpu_stall);
      nrst <= 1'b1;
      t0 = cyc;
      @(posedge sys_clk);
      bus(1'b0, FA, 8'h00);
      check("fast cfg reset", 8'h33, d);
      bus(1'b0, EA, 8'h00);
      check("enable reset", 8'h03, d);
      wait_stall_low();
      check("fast held after reset", 1, (cyc - t0) >= 161);
      count_rises();
      check("cpu fast div8", 4, nd);
      check("out div8", 4, no);
      $display("reset test done");
      // Slow chosen before the crystal is stable must stall the CPU
      bus(1'b1, EA, 8'h02);
      repeat (40) @(posedge sys_clk);
      check("early slow stall", 1, cpu_stall);
      wait_stall_low();
      check("slow start time", 1, (cyc - t0) >= 1481);
      $display("slow switch test done");
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].wd);
         bus(1'b0, rows[i].addr, 8'h00);
         check("readback", rows[i].ex, d);
         repeat (96) @(posedge sys_clk);
         count_rises();
         check("cpu fast rises", rows[i].n_div, nd);
         if (rows[i].n_out >= 0)
            check("out rises", rows[i].n_out, no);
         check("doubler rises", rows[i].n_dbl, nb);
         $display("row %0d done", i);
      end
      // Re-enable in RC mode: 128 pulses before fast clock returns
      bus(1'b1, EA, 8'h03);
      t0 = cyc;
      repeat (40) @(posedge sys_clk);
      check("early fast stall", 1, cpu_stall);
      wait_stall_low();
      check("fast start count", 1, (cyc - t0) >= 609);
      count_rises();
      check("cpu fast after enable", 4, nd);
      $display("fast enable test done");
      stop_enter <= 1'b1;
      @(posedge sys_clk);
      stop_enter <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check("crystal power in stop", 0, slow_osc_power);
      check("crystal drive in stop", 0, crystal_out_pin_oe);
      count_rises();
      check("slow rises in stop", 0, ns);
      ext_wake <= 1'b1;
      @(posedge sys_clk);
      ext_wake <= 1'b0;
      t0 = cyc;
      while (slow_clock !== 1'b1) @(posedge sys_clk);
      check("slow after wake", 1, (cyc - t0) >= 1481);
      $display("stop test done");
      conclude();
   end
endmodule

bind mcu_clock_generation mcu_clock_generation_assertions
   mcu_clock_generation_assertions_inst (.*);
